// ==== src/tipe_top.sv ====
// Timer interrupt pending/enable register block with APB access.
// Assumes timer conditions arrive as one-cycle pulses on pclk, one group per mode.
`timescale 1ns/1ps
`include "tipe_cfg.svh"
module tipe_top #(
  parameter int NSRC = `TIPE_NSRC,
  parameter int NMODE = `TIPE_NMODE
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TIPE_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Timer conditions, group m holds sources D..A for mode m
  input wire logic [NMODE*NSRC-1:0] timer_cond,
  // Interrupt side
  output logic timer_irq,
  output logic timer_irq_event,
  output logic [`TIPE_MODE_W-1:0] timer_mode
);
  tipe_bus_if rb ();

  logic [NSRC-1:0] src_irq_enable_r, src_irq_enable_nxt;
  logic [`TIPE_MODE_W-1:0] mode_r, mode_nxt;
  logic [NSRC-1:0] ovr_mask_r, ovr_mask_nxt;
  logic irq_r, irq_nxt;
  logic irq_evt_r, irq_evt_nxt;
  logic [NSRC-1:0] cond_sel;
  logic [NSRC-1:0] src_pending;
  logic [NSRC-1:0] src_ovr;
  logic [NSRC-1:0] clr_pend;
  logic [NSRC-1:0] clr_ovr;
  logic wr_ctrl, wr_clr, wr_stat, wr_cfg;
  tipe_pkg::tipe_byte_t ctrl_rd, stat_rd, cfg_rd;

  tipe_apb u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .pclk_en(pclk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .rb(rb)
  );

  // Address decode
  assign wr_ctrl = rb.wr && (rb.addr == `TIPE_OFF_CTRL);
  assign wr_clr = rb.wr && (rb.addr == `TIPE_OFF_CLR);
  assign wr_stat = rb.wr && (rb.addr == `TIPE_OFF_STAT);
  assign wr_cfg = rb.wr && (rb.addr == `TIPE_OFF_CFG);

  always_comb begin
    rb.hit = (rb.addr == `TIPE_OFF_CTRL) || (rb.addr == `TIPE_OFF_CLR)
             || (rb.addr == `TIPE_OFF_STAT) || (rb.addr == `TIPE_OFF_CFG);
    ctrl_rd = 8'h00;
    ctrl_rd[`TIPE_EN_LSB +: NSRC] = src_irq_enable_r;
    ctrl_rd[`TIPE_PND_LSB +: NSRC] = src_pending;
    stat_rd = 8'h00;
    stat_rd[`TIPE_PND_LSB +: NSRC] = src_pending;
    stat_rd[`TIPE_OVR_LSB +: NSRC] = src_ovr;
    cfg_rd = 8'h00;
    cfg_rd[`TIPE_MODE_LSB +: `TIPE_MODE_W] = mode_r;
    cfg_rd[`TIPE_OVRMSK_LSB +: NSRC] = ovr_mask_r;
    rb.rdata = 32'h0000_0000;
    // clear register reads as zero, being write-only
    if (rb.addr == `TIPE_OFF_CTRL) begin
      rb.rdata[7:0] = ctrl_rd;
    end else if (rb.addr == `TIPE_OFF_STAT) begin
      rb.rdata[7:0] = stat_rd;
    end else if (rb.addr == `TIPE_OFF_CFG) begin
      rb.rdata[7:0] = cfg_rd;
    end
  end

  always_comb begin
    cond_sel = '0;
    for (int m = 0; m < NMODE; m++) begin
      if (mode_r == m[`TIPE_MODE_W-1:0]) begin
        cond_sel = timer_cond[m*NSRC +: NSRC];
      end
    end
  end

  always_comb begin
    // only bits 3..0 act, upper bits reserved
    clr_pend = '0;
    if (wr_clr) begin
      clr_pend = clr_pend | rb.wdata[`TIPE_CLR_LSB +: NSRC];
    end
    // Status register offers the same write-one-to-clear
    if (wr_stat) begin
      clr_pend = clr_pend | rb.wdata[`TIPE_PND_LSB +: NSRC];
    end
    clr_ovr = wr_stat ? rb.wdata[`TIPE_OVR_LSB +: NSRC] : '0;
  end

  for (genvar s = 0; s < NSRC; s++) begin : g_src
    tipe_flag #(
      .RST_VAL(1'b0)
    ) u_flag (
      .clk(pclk),
      .rstn(presetn),
      .ce(pclk_en),
      .cond(cond_sel[s]),
      .clr_pend(clr_pend[s]),
      .clr_ovr(clr_ovr[s]),
      .pend(src_pending[s]),
      .ovr(src_ovr[s])
    );
  end

  always_comb begin
    src_irq_enable_nxt = src_irq_enable_r;
    mode_nxt = mode_r;
    ovr_mask_nxt = ovr_mask_r;
    // pending bits of control writes are dropped
    if (wr_ctrl) begin
      src_irq_enable_nxt = rb.wdata[`TIPE_EN_LSB +: NSRC];
    end
    if (wr_cfg) begin
      mode_nxt = rb.wdata[`TIPE_MODE_LSB +: `TIPE_MODE_W];
      ovr_mask_nxt = rb.wdata[`TIPE_OVRMSK_LSB +: NSRC];
    end
    irq_nxt = (|(src_pending & src_irq_enable_r)) || (|(src_ovr & ovr_mask_r));
    irq_evt_nxt = |(cond_sel & src_irq_enable_r);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_irq_enable_r <= NSRC'(`TIPE_CTRL_RST >> `TIPE_EN_LSB);
      mode_r <= `TIPE_MODE_RST;
      ovr_mask_r <= NSRC'(`TIPE_CFG_RST >> `TIPE_OVRMSK_LSB);
      irq_r <= 1'b0;
      irq_evt_r <= 1'b0;
    end else if (pclk_en) begin
      src_irq_enable_r <= src_irq_enable_nxt;
      mode_r <= mode_nxt;
      ovr_mask_r <= ovr_mask_nxt;
      irq_r <= irq_nxt;
      irq_evt_r <= irq_evt_nxt;
    end
  end

  assign timer_irq = irq_r;
  assign timer_irq_event = irq_evt_r;
  assign timer_mode = mode_r;
endmodule

// ==== src/tipe_cfg.svh ====
// Constants for the timer interrupt pending/enable block.
// Assumes a 32-bit APB bus with byte addresses and one word per register.
`ifndef TIPE_CFG_SVH
`define TIPE_CFG_SVH

`define TIPE_NSRC 4
`define TIPE_NMODE 4
`define TIPE_MODE_W 2
`define TIPE_ADDR_W 8

`define TIPE_OFF_CTRL 8'h00
`define TIPE_OFF_CLR 8'h04
`define TIPE_OFF_STAT 8'h08
`define TIPE_OFF_CFG 8'h0C

`define TIPE_EN_LSB 4
`define TIPE_PND_LSB 0
`define TIPE_OVR_LSB 4
`define TIPE_CLR_LSB 0
`define TIPE_MODE_LSB 0
`define TIPE_OVRMSK_LSB 4

`define TIPE_CTRL_RST 8'h00
`define TIPE_CFG_RST 8'h00
`define TIPE_MODE_RST 2'h0

`endif

// ==== src/tipe_pkg.sv ====
// Types shared by the timer interrupt pending/enable block.
// Assumes tipe_cfg.svh is available for the numeric constants.
package tipe_pkg;
  typedef enum logic {
    TIPE_APB_IDLE,
    TIPE_APB_ACK
  } tipe_apb_st_e;

  typedef logic [7:0] tipe_byte_t;
endpackage

// ==== src/tipe_bus_if.sv ====
// Internal register access carrier between the APB slave and the register file.
// Assumes one clock domain; strobes are single-cycle pulses.
`timescale 1ns/1ps
`include "tipe_cfg.svh"
interface tipe_bus_if;
  logic [`TIPE_ADDR_W-1:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic [31:0] rdata;
  logic hit;

  modport bus (
    output addr,
    output wdata,
    output wr,
    input rdata,
    input hit
  );

  modport regs (
    input addr,
    input wdata,
    input wr,
    output rdata,
    output hit
  );
endinterface

// ==== src/tipe_apb.sv ====
// APB slave front end: one wait state, registered answer.
// Assumes an APB master on pclk; the register file answers hit and rdata combinationally.
`timescale 1ns/1ps
`include "tipe_cfg.svh"
module tipe_apb (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TIPE_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Register file side
  tipe_bus_if.bus rb
);
  tipe_pkg::tipe_apb_st_e st_r, st_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;

  assign rb.addr = paddr;
  assign rb.wdata = pwdata;
  // Write lands only at the edge that completes the transfer
  assign rb.wr = pclk_en && (st_r == tipe_pkg::TIPE_APB_ACK) && psel && penable && pwrite
                 && rb.hit;

  always_comb begin
    st_nxt = st_r;
    pready_nxt = pready_r;
    pslverr_nxt = pslverr_r;
    prdata_nxt = prdata_r;
    unique case (st_r)
      tipe_pkg::TIPE_APB_IDLE: begin
        if (psel && penable) begin
          st_nxt = tipe_pkg::TIPE_APB_ACK;
          pready_nxt = 1'b1;
          pslverr_nxt = !rb.hit;
          prdata_nxt = (pwrite || !rb.hit) ? 32'h0000_0000 : rb.rdata;
        end
      end
      tipe_pkg::TIPE_APB_ACK: begin
        st_nxt = tipe_pkg::TIPE_APB_IDLE;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= tipe_pkg::TIPE_APB_IDLE;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (pclk_en) begin
      st_r <= st_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;
endmodule

// ==== src/tipe_flag.sv ====
// One interrupt source: sticky pending flag and sticky overrun flag.
// Assumes cond is a one-cycle pulse per occurrence on the same clock.
`timescale 1ns/1ps
module tipe_flag #(
  parameter bit RST_VAL = 1'b0
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Event and software clears
  input wire logic cond,
  input wire logic clr_pend,
  input wire logic clr_ovr,
  // State
  output logic pend,
  output logic ovr
);
  logic pend_r, pend_nxt;
  logic ovr_r, ovr_nxt;

  always_comb begin
    pend_nxt = pend_r;
    ovr_nxt = ovr_r;
    if (clr_pend) begin
      pend_nxt = 1'b0;
    end
    if (cond) begin
      pend_nxt = 1'b1;
    end
    if (clr_ovr) begin
      ovr_nxt = 1'b0;
    end
    // A second event before service is flagged, set wins over clear
    if (cond && pend_r) begin
      ovr_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_r <= RST_VAL;
      ovr_r <= 1'b0;
    end else if (ce) begin
      pend_r <= pend_nxt;
      ovr_r <= ovr_nxt;
    end
  end

  assign pend = pend_r;
  assign ovr = ovr_r;
endmodule

// ==== verification/tipe_asserts.sv ====
// Checker for tipe_top ports.
// Assumes enables change only by APB writes.
`timescale 1ns/1ps
`include "tipe_cfg.svh"
module tipe_asserts #(
  parameter int NSRC = 4,
  parameter int NMODE = 4
) (
  // Clock
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TIPE_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Timer
  input wire logic [NMODE*NSRC-1:0] timer_cond,
  input wire logic timer_irq,
  input wire logic timer_irq_event,
  input wire logic [`TIPE_MODE_W-1:0] timer_mode
);
  logic [NSRC-1:0] en_r, en_nxt, hit;
  logic rd;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow enables, so gating is judged per source
  always_comb begin
    en_nxt = en_r;
    if (pclk_en && psel && penable && pready && pwrite && paddr == `TIPE_OFF_CTRL) begin
      en_nxt = pwdata[`TIPE_EN_LSB +: NSRC];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= '0;
    end else begin
      en_r <= en_nxt;
    end
  end
  assign hit = timer_cond[timer_mode*NSRC +: NSRC] & en_r;
  assign rd = pready && !pwrite;
  chk_reset_quiet: assert property ($rose(presetn) |-> !timer_irq && !pready)
    else $error("busy after reset");
  chk_ready_wait: assert property ($rose(penable) && psel && pclk_en |=> pready)
    else $error("no ready");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready stuck");
  chk_err_map: assert property (pready && paddr[1:0] == 0 |-> pslverr == (paddr > 8'h0C))
    else $error("bad slverr");
  chk_clr_reads_zero: assert property (rd && paddr == `TIPE_OFF_CLR |-> prdata == 0)
    else $error("clear reg read");
  chk_ctrl_enables: assert property (rd && paddr == `TIPE_OFF_CTRL |->
    prdata[31:8] == 0 && prdata[`TIPE_EN_LSB +: NSRC] == en_r) else $error("enables");
  chk_event_on: assert property (pclk_en && |hit |=> timer_irq_event)
    else $error("no event");
  chk_event_off: assert property (pclk_en && hit == 0 |=> !timer_irq_event)
    else $error("stray event");
  chk_irq_follows: assert property (pclk_en && |hit |-> ##2 timer_irq)
    else $error("no irq");
  cover property (pready && pslverr);
  cover property (timer_irq_event);
  cover property ($fell(timer_irq));
endmodule
bind tipe_top tipe_asserts #(.NSRC(NSRC), .NMODE(NMODE)) u_chk (.pclk(pclk),
  .presetn(presetn), .pclk_en(pclk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .timer_cond(timer_cond), .timer_irq(timer_irq),
  .timer_irq_event(timer_irq_event), .timer_mode(timer_mode));

// ==== verification/tipe_cpu_model.sv ====
// CPU side of the timer interrupt: counts requests.
// Assumes request pulses on pclk.
`timescale 1ns/1ps
module tipe_cpu_model (
  // Clock
  input wire logic pclk,
  input wire logic presetn,
  // Request
  input wire logic timer_irq_event,
  output int n_evt
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_evt <= 0;
    end else if (timer_irq_event === 1'b1) begin
      n_evt <= n_evt + 1;
    end
  end
endmodule

// ==== verification/tb_timer_irq_pending_enable.sv ====
// Bench for tipe_top with a CPU model.
// Assumes pclk_en drops only between transfers.
`timescale 1ns/1ps
`include "tipe_cfg.svh"
module tb_timer_irq_pending_enable;
  logic pclk, presetn, pclk_en, psel, penable, pwrite;
  logic pready, pslverr, irq, evt, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] cond;
  logic [1:0] mode;
  int errors, n_tests, n_evt;
  tipe_top dut (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .timer_cond(cond),
    .timer_irq(irq), .timer_irq_event(evt), .timer_mode(mode));
  tipe_cpu_model cpu (.pclk(pclk), .presetn(presetn), .timer_irq_event(evt),
    .n_evt(n_evt));
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic wrap_up();
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Holding c over the access phase puts an event on the commit edge
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d, logic [15:0] c);
    int i;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    cond <= c;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 40);
    if (pready !== 1'b1) begin
      errors++;
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    cond <= 0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    xfer(1, a, d, 0);
  endtask
  task automatic rc(string nm, logic [7:0] a, logic [31:0] e);
    xfer(0, a, 0, 0);
    chk(nm, e, rd);
  endtask
  task automatic pulse(logic [15:0] c);
    @(posedge pclk);
    cond <= c;
    @(posedge pclk);
    cond <= 0;
  endtask
  task automatic t_regs();
    rc("rst", 8'h00, 32'h0);
    wr(8'h00, 32'hFFFF_FFFF);
    rc("ctrl", 8'h00, 32'hF0);
    rc("clr", 8'h04, 32'h0);
    xfer(0, 8'h40, 0, 0);
    chk("err", 32'h1, {31'h0, er});
    wr(8'h00, 32'h0);
  endtask
  task automatic t_masked();
    int n;
    n = n_evt;
    pulse(16'h000F);
    rc("pend", 8'h00, 32'h0F);
    wr(8'h00, 32'h0);
    rc("keep", 8'h00, 32'h0F);
    chk("irq", 32'h0, {31'h0, irq});
    chk("evt", 32'(n), 32'(n_evt));
    wr(8'h04, 32'hF5);
    rc("w1", 8'h00, 32'h0A);
    wr(8'h04, 32'h0);
    rc("w0", 8'h00, 32'h0A);
    wr(8'h04, 32'h0A);
  endtask
  task automatic t_enabled();
    int n;
    for (int i = 0; i < 4; i++) begin
      n = n_evt;
      wr(8'h00, 32'h10 << i);
      pulse(16'h000F);
      rc("ctrl", 8'h00, (32'h10 << i) | 32'h0F);
      chk("irq", 32'h1, {31'h0, irq});
      chk("evt", 32'(n + 1), 32'(n_evt));
      wr(8'h04, 32'h1 << i);
      rc("own", 8'h00, (32'h10 << i) | (32'h0F ^ (32'h1 << i)));
      chk("irq", 32'h0, {31'h0, irq});
      wr(8'h04, 32'h0F);
    end
    wr(8'h00, 32'h0);
  endtask
  task automatic t_mode();
    for (int m = 0; m < 4; m++) begin
      wr(8'h0C, 32'(m));
      pulse(16'h1 << (4 * ((m + 1) % 4)));
      chk("mode", 32'(m), {30'h0, mode});
      rc("other", 8'h00, 32'h0);
      pulse(16'h1 << (4 * m));
      rc("sel", 8'h00, 32'h1);
      wr(8'h04, 32'h1);
    end
    wr(8'h0C, 32'h0);
  endtask
  // Overrun, status clears and a frozen clock enable
  task automatic t_status();
    wr(8'h0C, 32'h10);
    pulse(16'h0001);
    pulse(16'h0001);
    rc("ovr", 8'h08, 32'h11);
    chk("ovr_irq", 32'h1, {31'h0, irq});
    wr(8'h08, 32'h10);
    rc("ovr_clr", 8'h08, 32'h01);
    chk("ovr_irq", 32'h0, {31'h0, irq});
    wr(8'h08, 32'h01);
    rc("stat_clr", 8'h00, 32'h0);
    rc("cfg", 8'h0C, 32'h10);
    wr(8'h0C, 32'h0);
    @(posedge pclk);
    pclk_en <= 0;
    pulse(16'h0001);
    pclk_en <= 1;
    rc("frz", 8'h00, 32'h0);
  endtask
  task automatic t_race();
    pulse(16'h0001);
    xfer(1, 8'h04, 32'h1, 16'h0001);
    rc("race", 8'h00, 32'h1);
    wr(8'h00, 32'hF0);
    presetn <= 0;
    pulse(16'h000F);
    presetn <= 1;
    rc("rst2", 8'h00, 32'h0);
  endtask
  initial begin
    errors = 0;
    n_tests = 0;
    presetn = 0;
    pclk_en = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    cond = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_masked();
    t_enabled();
    t_mode();
    t_status();
    t_race();
    wrap_up();
  end
endmodule
